// ==== common/fitp_pkg.sv ====
package fitp_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int unsigned NUM_COND = 4;
  localparam int unsigned NUM_IRQ = 4;
  localparam int unsigned SYNC_STAGES = 2;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_COND_DIR = 8'h00;
  localparam logic [7:0] OFS_COND_OUT = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN = 8'h08;
  localparam logic [7:0] OFS_IRQ_EDGE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ------------------------------------------------------------------
  // Status field positions
  // ------------------------------------------------------------------
  localparam int unsigned ST_COND_LSB = 0;
  localparam int unsigned ST_IRQ_LSB = 4;
  localparam int unsigned ST_STRAP_BIT = 8;
  localparam int unsigned ST_TMR_BIT = 9;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] RST_COND_DIR = 4'h0;
  localparam logic [3:0] RST_COND_OUT = 4'h0;
  localparam logic [3:0] RST_IRQ_EDGE = 4'h0;
  localparam logic [3:0] IRQ_EN_OFF = 4'h0;
  localparam logic [3:0] IRQ_EN_BOOT = 4'hF;
  localparam logic STRAP_IRQ_BOOT = 1'b1;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam logic [2:0] TMR_PULSE_CYCLES = 3'h4;

  // Captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } fitp_ahb_req_s;

endpackage

// ==== rtl/fitp_sync.sv ====
`timescale 1ns/1ps
// Multi-stage synchroniser; only the last stage is read outside
module fitp_sync #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned STAGES = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg [STAGES];

  // Shift chain, synchronous reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= RST_VAL;
      end
    end else begin
      stage_reg[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign sync_out = stage_reg[STAGES-1];

endmodule // fitp_sync

// ==== rtl/fitp_top.sv ====
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
// Overview of operation
// [RL1] Four condition pins, per-pin direction select
// [RL2] Condition pins reset to inputs, drivers off
// [RL3] Sampled condition pins feed the sequencer
// [RL4] Enabled low request raises interrupt event
// [RL5] Per-input edge or level detection
// [RL6] Requests disabled after reset unless boot strap
// [RL7] Timer expiry drives output four cycles
// [RL8] Timer pin sampled as strap during reset
// [RL9] Two-stage synchroniser before any detection
module fitp_top #(
  parameter int unsigned SYNC_STAGES = fitp_pkg::SYNC_STAGES
) (
  input wire logic clock,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Condition pins, three signals each
  input wire logic [3:0] program_condition_pins_in,
  output logic [3:0] program_condition_pins_out,
  output logic [3:0] program_condition_pins_oe,
  // Interrupt request pins, active low
  input wire logic [3:0] interrupt_request_pins_n,
  // Timer-expired pin, strap during reset
  input wire logic timer_expired_in,
  output logic timer_expired_out,
  output logic timer_expired_oe,
  // Core side
  input wire logic timer0_expire,
  output logic [3:0] seq_conditions,
  output logic [3:0] irq_events
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] cond_dir_reg;
  logic [3:0] cond_out_reg;
  logic [3:0] irq_en_reg;
  logic [3:0] irq_edge_reg;
  logic strap_reg;
  logic [3:0] cond_sync;
  logic [3:0] irq_sync_n;
  logic [3:0] irq_prev_n_reg;
  logic [3:0] irq_event_next;
  logic [2:0] tmr_cnt_reg;
  logic [2:0] tmr_cnt_next;
  fitp_pkg::fitp_ahb_req_s req_reg;
  logic [31:0] rdata_next;
  logic addr_phase;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Condition pin inputs
  fitp_sync #(
    .WIDTH(4),
    .STAGES(SYNC_STAGES),
    .RST_VAL(4'h0)
  ) u_cond_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(program_condition_pins_in),
    .sync_out(cond_sync)
  ); // RL9

  // Interrupt request inputs, idle high
  fitp_sync #(
    .WIDTH(4),
    .STAGES(SYNC_STAGES),
    .RST_VAL(4'hF)
  ) u_irq_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(interrupt_request_pins_n),
    .sync_out(irq_sync_n)
  ); // RL9

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign addr_phase = hsel && htrans[1] && hready;

  // Address phase capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_reg <= '0;
    end else begin
      req_reg.valid <= addr_phase;
      req_reg.write <= hwrite;
      req_reg.addr <= haddr[7:0];
    end
  end

  // Read mux, word aligned
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (haddr[7:0])
      fitp_pkg::OFS_COND_DIR: rdata_next[3:0] = cond_dir_reg;
      fitp_pkg::OFS_COND_OUT: rdata_next[3:0] = cond_out_reg;
      fitp_pkg::OFS_IRQ_EN: rdata_next[3:0] = irq_en_reg;
      fitp_pkg::OFS_IRQ_EDGE: rdata_next[3:0] = irq_edge_reg;
      fitp_pkg::OFS_STATUS: begin
        rdata_next[fitp_pkg::ST_COND_LSB +: 4] = cond_sync;
        rdata_next[fitp_pkg::ST_IRQ_LSB +: 4] = ~irq_sync_n;
        rdata_next[fitp_pkg::ST_STRAP_BIT] = strap_reg;
        rdata_next[fitp_pkg::ST_TMR_BIT] = timer_expired_out;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data for the data phase, zero wait, always OKAY
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Condition pin direction and drive value
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cond_dir_reg <= fitp_pkg::RST_COND_DIR; // RL2
      cond_out_reg <= fitp_pkg::RST_COND_OUT;
    end else if (req_reg.valid && req_reg.write) begin
      if (req_reg.addr == fitp_pkg::OFS_COND_DIR) begin
        cond_dir_reg <= hwdata[3:0]; // RL1
      end
      if (req_reg.addr == fitp_pkg::OFS_COND_OUT) begin
        cond_out_reg <= hwdata[3:0];
      end
    end
  end

  // Interrupt enable and mode; enable reset follows the strap
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_en_reg <= (timer_expired_in == fitp_pkg::STRAP_IRQ_BOOT) ?
        fitp_pkg::IRQ_EN_BOOT : fitp_pkg::IRQ_EN_OFF; // RL6
      irq_edge_reg <= fitp_pkg::RST_IRQ_EDGE;
    end else if (req_reg.valid && req_reg.write) begin
      if (req_reg.addr == fitp_pkg::OFS_IRQ_EN) begin
        irq_en_reg <= hwdata[3:0];
      end
      if (req_reg.addr == fitp_pkg::OFS_IRQ_EDGE) begin
        irq_edge_reg <= hwdata[3:0]; // RL5
      end
    end
  end

  // Strap capture while reset is held
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strap_reg <= timer_expired_in; // RL8
    end
  end

  // ----------------------------------------------------------------
  // Condition pins
  // ----------------------------------------------------------------
  // Pin drive and sequencer conditions
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      program_condition_pins_oe <= 4'h0; // RL2
      program_condition_pins_out <= 4'h0;
      seq_conditions <= 4'h0;
    end else begin
      program_condition_pins_oe <= cond_dir_reg; // RL1
      program_condition_pins_out <= cond_out_reg;
      seq_conditions <= cond_sync; // RL3
    end
  end

  // ----------------------------------------------------------------
  // Interrupt detection
  // ----------------------------------------------------------------
  // Edge: falling edge pulse; level: asserted while held low
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (irq_edge_reg[i]) begin
        irq_event_next[i] = irq_prev_n_reg[i] && !irq_sync_n[i]; // RL5
      end else begin
        irq_event_next[i] = !irq_sync_n[i];
      end
    end
    irq_event_next = irq_event_next & irq_en_reg; // RL4
  end

  // Previous sample and event register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_prev_n_reg <= 4'hF;
      irq_events <= 4'h0;
    end else begin
      irq_prev_n_reg <= irq_sync_n;
      irq_events <= irq_event_next; // RL4
    end
  end

  // ----------------------------------------------------------------
  // Timer-expired pulse
  // ----------------------------------------------------------------
  // Cycles left in the pulse; a new expiry restarts it
  always_comb begin
    if (timer0_expire) begin
      tmr_cnt_next = fitp_pkg::TMR_PULSE_CYCLES; // RL7
    end else if (tmr_cnt_reg != 3'h0) begin
      tmr_cnt_next = tmr_cnt_reg - 3'h1;
    end else begin
      tmr_cnt_next = 3'h0;
    end
  end

  // Output released from reset only after the strap is taken
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tmr_cnt_reg <= 3'h0;
      timer_expired_out <= 1'b0;
      timer_expired_oe <= 1'b0; // RL8
    end else begin
      tmr_cnt_reg <= tmr_cnt_next;
      timer_expired_out <= (tmr_cnt_next != 3'h0); // RL7
      timer_expired_oe <= 1'b1;
    end
  end

endmodule // fitp_top

// ==== sim/fitp_top_sva.sv ====
`timescale 1ns/1ps
// ----
// Pin and timer checks
// ----
module fitp_top_chk #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] program_condition_pins_in,
  input wire logic [3:0] program_condition_pins_oe,
  input wire logic [3:0] interrupt_request_pins_n,
  input wire logic timer0_expire,
  input wire logic timer_expired_out,
  input wire logic timer_expired_oe,
  input wire logic [3:0] seq_conditions,
  input wire logic [3:0] irq_events
);
  logic [2:0] up_cnt;

  // Cycles since reset release, saturating
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // One expiry followed by four quiet cycles
  sequence tmr_fire_q;
    timer0_expire ##1 !timer0_expire [*4];
  endsequence

  cond_reset_a: assert property ($rose(rst_n) |->
    (program_condition_pins_oe == 4'h0) [*2]) else $error("pins driven");
  cond_sync_a: assert property (up_cnt > 3'h4 |-> seq_conditions ==
    $past(program_condition_pins_in, SYNC_STAGES + 1))
    else $error("condition latency");
  irq_cause_a: assert property (up_cnt > 3'h4 |-> (irq_events &
    $past(interrupt_request_pins_n, SYNC_STAGES + 1)) == 4'h0)
    else $error("event without request");
  tmr_pulse_a: assert property (timer0_expire |=>
    timer_expired_out [*4]) else $error("pulse short");
  tmr_end_a: assert property (tmr_fire_q |=> !timer_expired_out)
    else $error("pulse long");
  tmr_cause_a: assert property ($rose(timer_expired_out) |->
    $past(timer0_expire)) else $error("pulse without expiry");
  tmr_oe_a: assert property ($rose(rst_n) |-> !timer_expired_oe
    ##1 timer_expired_oe) else $error("strap pin drive");
  tmr_drive_a: assert property (timer_expired_out |->
    timer_expired_oe) else $error("pulse not driven");
endmodule // fitp_top_chk

bind fitp_top fitp_top_chk #(.SYNC_STAGES(SYNC_STAGES)) chk_u (
  .clock(clock), .rst_n(rst_n),
  .program_condition_pins_in(program_condition_pins_in),
  .program_condition_pins_oe(program_condition_pins_oe),
  .interrupt_request_pins_n(interrupt_request_pins_n),
  .timer0_expire(timer0_expire), .timer_expired_out(timer_expired_out),
  .timer_expired_oe(timer_expired_oe), .seq_conditions(seq_conditions),
  .irq_events(irq_events));

// ==== sim/fitp_board.sv ====
`timescale 1ns/1ps
// ----
// Board side of the pins
// ----
module fitp_board (
  input wire logic [3:0] cond_oe,
  input wire logic [3:0] cond_out,
  input wire logic [3:0] cond_drv,
  input wire logic strap,
  input wire logic tmr_oe,
  input wire logic tmr_out,
  output logic [3:0] cond_pin,
  output logic tmr_pin
);
  // Device drive wins, board level elsewhere
  assign cond_pin = (cond_oe & cond_out) | (~cond_oe & cond_drv);
  // Strap level while device output is off
  assign tmr_pin = tmr_oe ? tmr_out : strap;
endmodule // fitp_board

// ==== sim/test_flag_irq_timer_pins.sv ====
`timescale 1ns/1ps
module test_flag_irq_timer_pins;
  logic clock, rst_n, hsel, hwrite, rph, t0, strap, hreadyout, hresp;
  logic tin, tout, toe;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [3:0] pin, cout, coe, irq_n, seqc, irqe, cdrv, d, o, cv;
  logic [7:0] ev_cnt [4] = '{default: 8'h00};
  logic [7:0] base [4];
  logic [31:0] q [$];
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  // ----
  // Clock, timeout, design
  // ----
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end
  fitp_top #(.SYNC_STAGES(2)) dut_u (.clock(clock), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .program_condition_pins_in(pin), .program_condition_pins_out(cout),
    .program_condition_pins_oe(coe), .interrupt_request_pins_n(irq_n),
    .timer_expired_in(tin), .timer_expired_out(tout),
    .timer_expired_oe(toe), .timer0_expire(t0), .seq_conditions(seqc),
    .irq_events(irqe));
  fitp_board board_u (.cond_oe(coe), .cond_out(cout), .cond_drv(cdrv),
    .strap(strap), .tmr_oe(toe), .tmr_out(tout), .cond_pin(pin),
    .tmr_pin(tin));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    rph <= ~w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rph <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  function automatic logic [31:0] st(input logic s, input logic [3:0] r);
    return {22'h0, 1'b0, s, r, cv};
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Read data compare and event counting
  always @(posedge clock) begin
    if (rph && hreadyout === 1'b1 && q.size() > 0) begin
      chk({31'h0, hresp}, 32'h0);
      chk(hrdata, q.pop_front());
    end
    for (int i = 0; i < 4; i++) begin
      ev_cnt[i] <= ev_cnt[i] + {7'h0, irqe[i]};
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rst_n = 1'b0;
    {hsel, hwrite, rph, t0, hwdata, haddr, htrans} = '0;
    strap = 1'b1;
    irq_n = 4'hF;
    cdrv = 4'($urandom(32));
    cv = cdrv;
    tk(8);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(fitp_pkg::OFS_COND_DIR, 32'h0);
    rd(fitp_pkg::OFS_IRQ_EN, 32'hF);
    rd(fitp_pkg::OFS_STATUS, st(1'b1, 4'h0));
    rd(8'h40, 32'h0);
    d = 4'($urandom);
    o = 4'($urandom);
    bus(1'b1, fitp_pkg::OFS_COND_DIR, {28'h0, d});
    bus(1'b1, fitp_pkg::OFS_COND_OUT, {28'h0, o});
    tk(4);
    cv = (d & o) | (~d & cdrv);
    rd(fitp_pkg::OFS_STATUS, st(1'b1, 4'h0));
    chk({28'h0, seqc}, {28'h0, cv});
    bus(1'b1, fitp_pkg::OFS_IRQ_EN, 32'h3);
    bus(1'b1, fitp_pkg::OFS_IRQ_EDGE, 32'h1);
    tk(2);
    base = ev_cnt;
    irq_n <= 4'h0;
    tk(6);
    rd(fitp_pkg::OFS_STATUS, st(1'b1, 4'hF));
    irq_n <= 4'hF;
    tk(8);
    chk({24'h0, ev_cnt[0] - base[0]}, 32'h1);
    chk({24'h0, ev_cnt[1] - base[1]}, 32'h8);
    chk({16'h0, ev_cnt[2] - base[2], ev_cnt[3] - base[3]}, 32'h0);
    t0 <= 1'b1;
    @(posedge clock);
    t0 <= 1'b0;
    rd(fitp_pkg::OFS_STATUS, st(1'b1, 4'h0) | 32'h200);
    t0 <= 1'b1;
    @(posedge clock);
    t0 <= 1'b0;
    tk(8);
    rd(fitp_pkg::OFS_STATUS, st(1'b1, 4'h0));
    strap <= 1'b0;
    rst_n <= 1'b0;
    tk(8);
    rst_n <= 1'b1;
    cv = cdrv;
    @(posedge clock);
    rd(fitp_pkg::OFS_IRQ_EN, 32'h0);
    rd(fitp_pkg::OFS_STATUS, st(1'b0, 4'h0));
    tk(2);
    summarize();
  end
endmodule // test_flag_irq_timer_pins
